// [logic/asdc_pkg.sv]
// package: register map, reset values, field layout and carriers of the set-point and drive control block
package asdc_pkg;

   // register byte offsets on the wishbone bus
   localparam logic [7:0] ASDC_OFF_MAIN_SETPOINT = 8'h00;
   localparam logic [7:0] ASDC_OFF_SECOND_REF = 8'h04;
   localparam logic [7:0] ASDC_OFF_PERIPH_EN = 8'h08;
   localparam logic [7:0] ASDC_OFF_CAL_WORD = 8'h0C;
   localparam logic [7:0] ASDC_OFF_DEADTIME = 8'h10;
   localparam logic [7:0] ASDC_OFF_ROLE = 8'h14;
   localparam logic [7:0] ASDC_OFF_ABLOCK = 8'h18;

   // reset values
   localparam logic [7:0] ASDC_RST_MAIN_SETPOINT = 8'h00;
   localparam logic [7:0] ASDC_RST_SECOND_REF = 8'h00;
   localparam logic [7:0] ASDC_RST_PERIPH_EN = 8'h00;
   localparam logic [7:0] ASDC_RST_DEADTIME = 8'h00;
   localparam logic [7:0] ASDC_RST_ROLE = 8'h00;
   localparam logic [7:0] ASDC_RST_ABLOCK = 8'h00;

   // driver_peripheral_enable bit positions
   localparam int ASDC_PE_PRI_DRV = 7;
   localparam int ASDC_PE_SEC_DRV = 6;
   localparam int ASDC_PE_PRI_BYP = 5;
   localparam int ASDC_PE_SEC_BYP = 4;
   localparam int ASDC_PE_UNUSED = 3;
   localparam int ASDC_PE_PULLUP = 2;
   localparam int ASDC_PE_PRI_STEER = 1;
   localparam int ASDC_PE_SEC_STEER = 0;
   // writable bits; bit 3 reads zero
   localparam logic [7:0] ASDC_PE_WMASK = 8'hF7;

   // deadtime_code_register: primary code in [7:4], secondary in [3:0]
   localparam int ASDC_DT_PRI_LSB = 4;
   localparam int ASDC_DT_SEC_LSB = 0;

   // topology_role_register: role_select_field in [7:6], feedback mux in [5]
   localparam int ASDC_ROLE_LSB = 6;
   localparam logic [7:0] ASDC_ROLE_WMASK = 8'hE0;

   // analog_block_enable layout; bit 2 reads zero
   localparam int ASDC_AB_DIG_OE = 7;
   localparam int ASDC_AB_DSEL_LSB = 4;
   localparam int ASDC_AB_ANA_OE = 0;
   localparam logic [7:0] ASDC_AB_WMASK = 8'hFB;

   // role codes
   typedef enum logic [1:0] {
      ASDC_ROLE_STANDALONE = 2'h0,
      ASDC_ROLE_MASTER = 2'h1,
      ASDC_ROLE_SLAVE = 2'h2,
      ASDC_ROLE_RESERVED = 2'h3
   } asdc_role_t;

   // digital test select code that has no source
   localparam logic [2:0] ASDC_DSEL_NONE = 3'h7;

   // dead time timing
   localparam int ASDC_CLK_PERIOD_PS = 4000;
   localparam int ASDC_DT_STEP_NS = 16;
   localparam int ASDC_DT_STEP_CYC = (ASDC_DT_STEP_NS * 1000 + ASDC_CLK_PERIOD_PS - 1) / ASDC_CLK_PERIOD_PS;

   // drive-side controls handed to the gate drivers
   typedef struct packed {
      logic pri_enable;
      logic sec_enable;
      logic pri_bypass;
      logic sec_bypass;
      logic [6:0] pri_dead_cyc;
      logic [6:0] sec_dead_cyc;
      logic pullup_enable;
      logic pri_steer_pwm;
      logic sec_steer_pwm;
   } asdc_drive_t;

   // debug pin and test routing
   typedef struct packed {
      logic pin_out;
      logic pin_oe;
      logic ana_to_pin;
      logic ana_to_adc;
   } asdc_debug_t;

   // steering timer inputs
   typedef struct packed {
      logic [7:0] period;
      logic [7:0] duty;
   } asdc_timer_t;

   // register and bus state of the main module
   typedef struct packed {
      logic [7:0] main_setpoint;
      logic [7:0] second_ref;
      logic [7:0] periph_en;
      logic [7:0] deadtime;
      logic [7:0] role;
      logic [7:0] ablock;
      logic ack;
      logic [31:0] rdata;
      logic [2:0] ovp_sync;
      logic ovp;
      asdc_debug_t dbg;
      logic pri_pwm;
      logic sec_pwm;
   } asdc_state_t;

   // steering counter state
   typedef struct packed {
      logic [7:0] count;
      logic pwm;
   } asdc_steer_state_t;

endpackage

// [logic/asdc_steer.sv]
// open-loop steering pwm generator: period and duty from the micro timers
`timescale 1ns/10ps
module asdc_steer
   import asdc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire asdc_timer_t timer_i,
   output logic pwm_o
);

   asdc_steer_state_t st;
   asdc_steer_state_t next_st;

   always_comb begin
      next_st = st;
      if (!run_i) begin
         next_st.count = 8'h00;
         next_st.pwm = 1'b0;
      end else begin
         // period counts 0..period, so frequency follows the timer period
         if (st.count >= timer_i.period) begin
            next_st.count = 8'h00;
         end else begin
            next_st.count = st.count + 8'h01;
         end
         next_st.pwm = (next_st.count < timer_i.duty);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign pwm_o = st.pwm;

endmodule // asdc_steer

// [logic/asdc_regs.sv]
// set-point dacs, driver peripheral enable, test mux and wishbone register slave
//
// Contract
// - main set-point register, 8 bits read/write, resets to zero, feeds pedestal dac.
// - read-only 8-bit gain calibration word for the sense amplifier.
// - second reference register, 8 bits read/write, resets zero, no pedestal.
// - second reference reaches its pin only in master role.
// - bit 7 enables the primary gate driver, resets zero.
// - bit 6 enables the secondary gate driver independently, resets zero.
// - per-driver 4-bit dead time code, 16 ns steps from 16 to 256 ns.
// - bits 5 and 4 bypass primary and secondary dead time.
// - bit 3 unimplemented, ignores writes, reads zero.
// - bit 2 enables weak pull-up on the secondary sense pin.
// - bit 1 applies open-loop fixed pwm to primary driver only.
// - bit 0 applies open-loop fixed pwm to secondary driver only.
// - secondary steering pulses only while overvoltage protection is active.
// - with both steering bits set, primary steering wins; software avoids it.
// - steering period from timer_b_period, duty from timer_a_low_byte.
// - digital test output beats analog on the debug pin.
// - analog test signal goes to internal adc when its pin enable is clear.
// - 3-bit digital select picks one of seven signals; code 111 unused.
// - role field 00 stand-alone, 01 master, 10 slave, 11 reserved.
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/10ps
module asdc_regs
   import asdc_pkg::*;
#(
   parameter logic [7:0] AMP_GAIN_CAL_VALUE = 8'h80 // arbitrary factory value, overridden per part
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // analog side
   input wire logic ovp_active_i,
   input wire logic [6:0] dig_test_i,
   input wire asdc_timer_t timer_i,
   output logic [7:0] main_setpoint_code_o,
   output logic [7:0] second_reference_code_o,
   output logic second_ref_pin_enable_o,
   output logic [1:0] role_select_field_o,
   output asdc_drive_t drive_o,
   output asdc_debug_t debug_o
);

   asdc_state_t st;
   asdc_state_t next_st;
   logic steer_pwm;
   logic steer_run;
   logic wr_now;
   logic [7:0] wr_byte;

   // dead time in clock cycles for one 4-bit code; zero when bypassed
   function automatic logic [6:0] dead_cycles(input logic [3:0] code, input logic bypass);
      logic [6:0] steps;
      steps = {3'h0, code} + 7'h01;
      if (bypass) begin
         dead_cycles = 7'h00;
      end else begin
         dead_cycles = 7'(steps * 7'(ASDC_DT_STEP_CYC));
      end
   endfunction

   // masked byte-lane-0 write merge
   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] din, input logic [7:0] mask);
      merge = (old & ~mask) | (din & mask);
   endfunction

   // read mux, unmapped offsets read zero
   function automatic logic [7:0] read_byte(input asdc_state_t s, input logic [7:0] adr);
      unique case (adr)
         ASDC_OFF_MAIN_SETPOINT: read_byte = s.main_setpoint;
         ASDC_OFF_SECOND_REF: read_byte = s.second_ref;
         ASDC_OFF_PERIPH_EN: read_byte = s.periph_en & ASDC_PE_WMASK;
         ASDC_OFF_CAL_WORD: read_byte = AMP_GAIN_CAL_VALUE;
         ASDC_OFF_DEADTIME: read_byte = s.deadtime;
         ASDC_OFF_ROLE: read_byte = s.role & ASDC_ROLE_WMASK;
         ASDC_OFF_ABLOCK: read_byte = s.ablock & ASDC_AB_WMASK;
         default: read_byte = 8'h00;
      endcase
   endfunction

   // the write lands on the edge that samples ack high
   assign wr_now = wb_cyc_i && wb_stb_i && wb_we_i && st.ack && wb_sel_i[0];
   assign wr_byte = wb_dat_i[7:0];

   // steering counter runs while either steering bit is set
   assign steer_run = st.periph_en[ASDC_PE_PRI_STEER] || st.periph_en[ASDC_PE_SEC_STEER];

   asdc_steer u_steer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(steer_run),
      .timer_i(timer_i),
      .pwm_o(steer_pwm)
   );

   always_comb begin
      logic [2:0] dsel;
      logic dig_on;
      logic ana_on;
      logic dig_bit;
      dsel = 3'h0;
      dig_on = 1'b0;
      ana_on = 1'b0;
      dig_bit = 1'b0;
      next_st = st;

      // bus: single-cycle registered ack, dropped the cycle after
      next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
      if (wb_cyc_i && wb_stb_i && !st.ack) begin
         next_st.rdata = {24'h000000, read_byte(st, wb_adr_i)};
      end

      if (wr_now) begin
         unique case (wb_adr_i)
            ASDC_OFF_MAIN_SETPOINT: begin
               next_st.main_setpoint = wr_byte;
            end
            ASDC_OFF_SECOND_REF: begin
               next_st.second_ref = wr_byte;
            end
            ASDC_OFF_PERIPH_EN: begin
               // bit 3 is never stored
               next_st.periph_en = merge(st.periph_en, wr_byte, ASDC_PE_WMASK);
            end
            ASDC_OFF_DEADTIME: begin
               next_st.deadtime = wr_byte;
            end
            ASDC_OFF_ROLE: begin
               next_st.role = merge(st.role, wr_byte, ASDC_ROLE_WMASK);
            end
            ASDC_OFF_ABLOCK: begin
               next_st.ablock = merge(st.ablock, wr_byte, ASDC_AB_WMASK);
            end
            default: begin
               // calibration word and unmapped offsets ignore writes
               next_st.rdata = st.rdata;
            end
         endcase
      end

      // overvoltage flag comes from an analog comparator: three flops,
      // a change is taken once the second and third agree
      next_st.ovp_sync = {st.ovp_sync[1:0], ovp_active_i};
      if (st.ovp_sync[1] == st.ovp_sync[2]) begin
         next_st.ovp = st.ovp_sync[2];
      end

      // steering gating; primary dominates when both are set
      next_st.pri_pwm = st.periph_en[ASDC_PE_PRI_STEER] && steer_pwm;
      next_st.sec_pwm = st.periph_en[ASDC_PE_SEC_STEER] && !st.periph_en[ASDC_PE_PRI_STEER]
                        && st.ovp && steer_pwm;

      // debug pin routing
      dsel = st.ablock[ASDC_AB_DSEL_LSB +: 3];
      dig_on = st.ablock[ASDC_AB_DIG_OE];
      ana_on = st.ablock[ASDC_AB_ANA_OE];
      if (dsel == ASDC_DSEL_NONE) begin
         dig_bit = 1'b0;
      end else begin
         dig_bit = dig_test_i[dsel];
      end
      next_st.dbg.pin_out = dig_on && dig_bit;
      next_st.dbg.pin_oe = dig_on;
      next_st.dbg.ana_to_pin = ana_on && !dig_on;
      next_st.dbg.ana_to_adc = !ana_on;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
         st.main_setpoint <= ASDC_RST_MAIN_SETPOINT;
         st.second_ref <= ASDC_RST_SECOND_REF;
         st.periph_en <= ASDC_RST_PERIPH_EN;
         st.deadtime <= ASDC_RST_DEADTIME;
         st.role <= ASDC_RST_ROLE;
         st.ablock <= ASDC_RST_ABLOCK;
      end else begin
         st <= next_st;
      end
   end

   // bus outputs
   assign wb_ack_o = st.ack;
   assign wb_dat_o = st.rdata;

   // dac codes straight from the registers, so they move on the write edge
   assign main_setpoint_code_o = st.main_setpoint;
   assign second_reference_code_o = st.second_ref;
   assign role_select_field_o = st.role[ASDC_ROLE_LSB +: 2];
   // slave and reserved codes keep the reference off the pin as well
   assign second_ref_pin_enable_o = (st.role[ASDC_ROLE_LSB +: 2] == ASDC_ROLE_MASTER);

   // gate driver controls
   assign drive_o.pri_enable = st.periph_en[ASDC_PE_PRI_DRV];
   assign drive_o.sec_enable = st.periph_en[ASDC_PE_SEC_DRV];
   assign drive_o.pri_bypass = st.periph_en[ASDC_PE_PRI_BYP];
   assign drive_o.sec_bypass = st.periph_en[ASDC_PE_SEC_BYP];
   assign drive_o.pri_dead_cyc = dead_cycles(st.deadtime[ASDC_DT_PRI_LSB +: 4],
                                             st.periph_en[ASDC_PE_PRI_BYP]);
   assign drive_o.sec_dead_cyc = dead_cycles(st.deadtime[ASDC_DT_SEC_LSB +: 4],
                                             st.periph_en[ASDC_PE_SEC_BYP]);
   assign drive_o.pullup_enable = st.periph_en[ASDC_PE_PULLUP];
   assign drive_o.pri_steer_pwm = st.pri_pwm;
   assign drive_o.sec_steer_pwm = st.sec_pwm;

   assign debug_o = st.dbg;

endmodule // asdc_regs

// [verif/asdc_regs_monitor.sv]
// checker: bus handshake, write effect and output relations of the register block
`timescale 1ns/10ps
module asdc_regs_monitor
   import asdc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic ovp_active_i,
   input wire logic [6:0] dig_test_i,
   input wire asdc_timer_t timer_i,
   input wire logic [7:0] main_setpoint_code_o,
   input wire logic [7:0] second_reference_code_o,
   input wire logic second_ref_pin_enable_o,
   input wire logic [1:0] role_select_field_o,
   input wire asdc_drive_t drive_o,
   input wire asdc_debug_t debug_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_wr(logic [7:0] a);
      wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == a;
   endsequence
   a_ack_follows_req: assert property (s_req |=> wb_ack_o)
      else $error("no ack one cycle after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_main_write: assert property (s_wr(ASDC_OFF_MAIN_SETPOINT) |=> main_setpoint_code_o == $past(wb_dat_i[7:0]))
      else $error("set-point output not updated by write");
   a_drive_write: assert property (s_wr(ASDC_OFF_PERIPH_EN) |=> drive_o.pri_enable == $past(wb_dat_i[7])
      && drive_o.sec_enable == $past(wb_dat_i[6])) else $error("driver enables not updated by write");
   a_unused_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ASDC_OFF_PERIPH_EN |-> !wb_dat_o[3])
      else $error("unimplemented enable bit read as one");
   a_pin_master: assert property (second_ref_pin_enable_o == (role_select_field_o == 2'h1))
      else $error("second reference pin routing wrong for role");
   a_bypass_zero: assert property (drive_o.pri_bypass |-> drive_o.pri_dead_cyc == 7'h00)
      else $error("bypassed primary still has dead time");
   a_dead_step: assert property (!drive_o.sec_bypass |-> drive_o.sec_dead_cyc[1:0] == 2'h0
      && drive_o.sec_dead_cyc != 7'h00 && drive_o.sec_dead_cyc <= 7'h40) else $error("dead time off the step grid");
   a_steer_excl: assert property (drive_o.sec_steer_pwm |-> !drive_o.pri_steer_pwm)
      else $error("both steering outputs high");
   a_sec_needs_ovp: assert property (!ovp_active_i [*8] |=> !drive_o.sec_steer_pwm)
      else $error("secondary steering without overvoltage");
   a_dig_prio: assert property (debug_o.pin_oe |-> !debug_o.ana_to_pin)
      else $error("analog test reached pin over digital");
endmodule // asdc_regs_monitor

bind asdc_regs asdc_regs_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .ovp_active_i(ovp_active_i), .dig_test_i(dig_test_i), .timer_i(timer_i),
   .main_setpoint_code_o(main_setpoint_code_o), .second_reference_code_o(second_reference_code_o),
   .second_ref_pin_enable_o(second_ref_pin_enable_o), .role_select_field_o(role_select_field_o),
   .drive_o(drive_o), .debug_o(debug_o));

// [verif/tb.sv]
// testbench: register access, drive controls, steering and debug routing
`timescale 1ns/10ps
module tb
   import asdc_pkg::*;
;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, ovp_active_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00, main_setpoint_code_o, second_reference_code_o;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic [6:0] dig_test_i = 7'h55;
   asdc_timer_t timer_i = 16'h0302; // period 3, duty 2: high 2 of every 4 cycles
   logic wb_ack_o, second_ref_pin_enable_o;
   logic [1:0] role_select_field_o;
   asdc_drive_t drive_o;
   asdc_debug_t debug_o;
   int n_fail = 0, n_tests = 0, cyc_cnt = 0, np, ns;
   logic [15:0] prod;
   logic [7:0] av [3] = '{8'h01, 8'h81, 8'h00};
   logic [2:0] ae [3] = '{3'h2, 3'h4, 3'h1};

   asdc_regs uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .ovp_active_i(ovp_active_i), .dig_test_i(dig_test_i), .timer_i(timer_i),
      .main_setpoint_code_o(main_setpoint_code_o), .second_reference_code_o(second_reference_code_o),
      .second_ref_pin_enable_o(second_ref_pin_enable_o), .role_select_field_o(role_select_field_o),
      .drive_o(drive_o), .debug_o(debug_o));

   always #2 clk_i = ~clk_i;

   task automatic results();
      if (n_fail == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // the hang guard: a stuck ack wait ends here
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 6000) begin
         n_fail++;
         results();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // leading edge keeps cyc low for a cycle between accesses
   task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= a; wb_sel_i <= s; wb_dat_i <= {24'h0, d};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d, 4'hF);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00, 4'hF);
      check(rd, {24'h0, e});
   endtask

   // debug outputs are registered one cycle behind the registers
   task automatic settle();
      repeat (2) @(posedge clk_i);
      #1;
   endtask

   task automatic cnt();
      np = 0; ns = 0;
      repeat (32) begin
         @(posedge clk_i);
         np += drive_o.pri_steer_pwm;
         ns += drive_o.sec_steer_pwm;
      end
   endtask

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      settle();
      check({11'h0, drive_o}, 32'h0000_1020);
      check({28'h0, debug_o}, 32'h0000_0001);
      for (int i = 0; i < 8; i++) rdchk(8'(i * 4), (i == 3) ? 8'h80 : 8'h00);
      wr(ASDC_OFF_CAL_WORD, 8'hFF); rdchk(ASDC_OFF_CAL_WORD, 8'h80);
      wr(ASDC_OFF_MAIN_SETPOINT, 8'hA5);
      xfer(1'b1, ASDC_OFF_MAIN_SETPOINT, 8'h3C, 4'hE); rdchk(ASDC_OFF_MAIN_SETPOINT, 8'hA5);
      wr(ASDC_OFF_SECOND_REF, 8'hFF); rdchk(ASDC_OFF_SECOND_REF, 8'hFF);
      settle();
      check({16'h0, main_setpoint_code_o, second_reference_code_o}, 32'h0000_A5FF);
      // gain trim done the firmware way: code times trim word, rotated right, low byte kept
      rdchk(ASDC_OFF_CAL_WORD, 8'h80);
      prod = {8'h00, rd[7:0]} * 16'h00A5;
      prod = {prod[0], prod[15:1]};
      wr(ASDC_OFF_MAIN_SETPOINT, prod[7:0]);
      #1;
      check(main_setpoint_code_o, 8'h40);
      // reference trim: clear, then step up one code at a time to code 3, checking each write
      for (int v = 0; v < 4; v++) begin
         wr(ASDC_OFF_SECOND_REF, 8'(v));
         #1;
         check(second_reference_code_o, 8'(v));
      end
      wr(ASDC_OFF_PERIPH_EN, 8'hFF); rdchk(ASDC_OFF_PERIPH_EN, 8'hF7);
      wr(ASDC_OFF_PERIPH_EN, 8'h84); settle();
      check({drive_o.pri_enable, drive_o.sec_enable, drive_o.pullup_enable}, 3'h5);
      wr(ASDC_OFF_PERIPH_EN, 8'h40); wr(ASDC_OFF_DEADTIME, 8'hF0); settle();
      check({drive_o.pri_enable, drive_o.sec_enable, drive_o.pullup_enable}, 3'h2);
      check({drive_o.pri_dead_cyc, drive_o.sec_dead_cyc}, {7'h40, 7'h04});
      wr(ASDC_OFF_PERIPH_EN, 8'h20); settle();
      check({drive_o.pri_dead_cyc, drive_o.sec_dead_cyc}, {7'h00, 7'h04});
      for (int r = 0; r < 4; r++) begin
         wr(ASDC_OFF_ROLE, {2'(r), 6'h00}); settle();
         check({second_ref_pin_enable_o, role_select_field_o}, {r == 1, 2'(r)});
      end
      wr(ASDC_OFF_ROLE, 8'hFF); rdchk(ASDC_OFF_ROLE, 8'hE0);
      for (int c = 0; c < 8; c++) begin
         wr(ASDC_OFF_ABLOCK, {1'b1, 3'(c), 4'h0}); settle();
         check({debug_o.pin_out, debug_o.pin_oe}, {(c < 7) && (c % 2 == 0), 1'b1});
      end
      for (int k = 0; k < 3; k++) begin
         wr(ASDC_OFF_ABLOCK, av[k]); settle();
         check(debug_o[2:0], ae[k]);
      end
      // secondary steering sits behind the overvoltage input synchroniser, so wait it out
      wr(ASDC_OFF_PERIPH_EN, 8'h01);
      // the bench plays firmware and keeps the desat comparator output off while steering
      dig_test_i <= 7'h54;
      settle(); repeat (8) @(posedge clk_i); cnt();
      check(ns, 32'h0);
      check(np, 32'h0);
      ovp_active_i <= 1'b1; repeat (10) @(posedge clk_i); cnt();
      check(np, 32'h0);
      check(ns, 32'h10);
      wr(ASDC_OFF_PERIPH_EN, 8'h03); settle(); cnt();
      check(np, 32'h10);
      check(ns, 32'h0);
      results();
   end
endmodule // tb
